// [tnisc_pkg.sv]
package tnisc_pkg;
    // control register one: one byte at the plain port
    localparam logic [3:0] TNISC_OFF_CTRL1 = 4'h0;
    localparam logic [3:0] TNISC_OFF_STAGE = 4'h1;
    localparam logic [3:0] TNISC_OFF_OWN = 4'h2;
    localparam logic [3:0] TNISC_OFF_SUCC = 4'h3;
    localparam logic [3:0] TNISC_OFF_STAT = 4'h4;
    localparam int TNISC_BIT_UPDATE = 0;
    localparam int TNISC_BIT_DRIVE = 4;
    localparam int TNISC_BIT_INIT = 5;
    localparam int TNISC_BIT_PIGGY = 6;
    localparam int TNISC_BIT_DIAG = 7;
    localparam logic [7:0] TNISC_CTRL1_RST = 8'h00;
    localparam logic [7:0] TNISC_CTRL1_MASK = 8'hf1;
    localparam logic [7:0] TNISC_ADDR_MIN = 8'h01;
    localparam logic [7:0] TNISC_ADDR_MAX = 8'hfe;
    localparam logic [7:0] TNISC_OWN_RST = 8'h01;
    localparam int TNISC_RESP_WINDOW_NS = 2000;
    localparam int TNISC_CLK_PERIOD_NS = 10;
    localparam int TNISC_RESP_CYCLES = (TNISC_RESP_WINDOW_NS + TNISC_CLK_PERIOD_NS - 1) / TNISC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {TNISC_IDLE, TNISC_PASS, TNISC_WAIT} tnisc_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tnisc_bus_t;

    typedef struct packed {
        logic lastByLimit;
        logic lastByStatus;
        logic lastByChainEnd;
    } tnisc_txend_t;
endpackage : tnisc_pkg

// [tnisc_core.sv]
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
// How it works
// - drive 0: address pins driven only during low ack
// - drive 1: address pins always driven
// - init clear: timer expiry does nothing
// - init set: timer expiry starts scan
// - scan passes token to each higher address
// - scan ends on activity or own address
// - scan starts at current successor address
// - network entry: successor becomes own plus one
// - host stages successor and sets update flag
// - scan frame received: successor becomes own plus one
// - successful scan records responder as successor
// - increments wrap within 1 to 254
// - piggyback set: token rides last data frame
// - piggyback only for limit or status-block last
// - no piggyback at end of chain
// - update copies staging, then self-clears
module tnisc_core
    import tnisc_pkg::*;
#(
    parameter int RESP_CYCLES = TNISC_RESP_CYCLES
)
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire tnisc_bus_t bus, // register port request
    output logic [7:0] rdata, // read data, cycle after strobe
    input wire logic [15:0] dmaAddr, // address from the dma engine
    input wire logic dmaAckInN, // dma acknowledge pin, active low
    output logic [15:0] addrOut, // address pin outputs
    output logic addrOe, // address pin output enable
    input wire logic deadNetTimer, // dead network timer expiry pulse
    input wire logic netEnter, // pulse on entering network state
    input wire logic netActivity, // pulse when another node responds
    input wire logic [7:0] responder, // address of responding node
    input wire logic scanFrameRx, // pulse: scan frame received
    input wire tnisc_txend_t txEnd, // last-frame cause at end of transmission
    input wire logic txEndValid, // pulse: transmission of last frame decided
    output logic tokenPass, // one-cycle token pass request
    output logic [7:0] tokenDest, // destination of the token pass
    output logic piggyback, // one-cycle: token rides last data frame
    output logic scanActive // scan mode in progress
);
    // the response counter is 16 bits wide and must count at least once
    if (RESP_CYCLES < 1 || RESP_CYCLES > 65535)
    begin : g_resp_check
        $error("RESP_CYCLES out of range");
    end

    function automatic logic [7:0] nextAddr(input logic [7:0] a);
        nextAddr = (a >= TNISC_ADDR_MAX || a < TNISC_ADDR_MIN) ? TNISC_ADDR_MIN : a + 8'h01;
    endfunction : nextAddr

    ////////////////////////////////////////////////////////////////////////////////
    // synchroniser for the acknowledge pin
    logic [2:0] ackSync_r, ackSync_nxt;
    logic ackLow_r, ackLow_nxt;
    always_comb
    begin
        ackSync_nxt = {ackSync_r[1:0], dmaAckInN};
        ackLow_nxt = ackLow_r;
        if (ackSync_r[1] == ackSync_r[2])
            ackLow_nxt = ~ackSync_r[2];
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ackSync_r <= 3'h7;
            ackLow_r <= 1'b0;
        end
        else
        begin
            ackSync_r <= ackSync_nxt;
            ackLow_r <= ackLow_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers and scan engine
    logic [7:0] ctrl1_r, ctrl1_nxt;
    logic [7:0] stage_r, stage_nxt;
    logic [7:0] own_r, own_nxt;
    logic [7:0] succ_r, succ_nxt;
    logic [7:0] scanAddr_r, scanAddr_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [15:0] waitCnt_r, waitCnt_nxt;
    tnisc_state_t state_r, state_nxt;
    logic tokenPass_r, tokenPass_nxt;
    logic piggy_r, piggy_nxt;
    logic [15:0] addrOut_r, addrOut_nxt;
    logic addrOe_r, addrOe_nxt;
    logic scanActive_r, scanActive_nxt;
    logic wrCtrl;

    assign wrCtrl = bus.wr && bus.addr == TNISC_OFF_CTRL1;

    always_comb
    begin
        ctrl1_nxt = ctrl1_r;
        stage_nxt = stage_r;
        own_nxt = own_r;
        succ_nxt = succ_r;
        scanAddr_nxt = scanAddr_r;
        waitCnt_nxt = waitCnt_r;
        state_nxt = state_r;
        tokenPass_nxt = 1'b0;
        piggy_nxt = 1'b0;
        rdata_nxt = 8'h00;
        if (wrCtrl)
            ctrl1_nxt = bus.wdata & TNISC_CTRL1_MASK;
        if (bus.wr && bus.addr == TNISC_OFF_STAGE)
            stage_nxt = bus.wdata;
        if (bus.wr && bus.addr == TNISC_OFF_OWN)
            own_nxt = bus.wdata;
        // update flag: copy staging, then clear; a fresh host set wins
        if (ctrl1_r[TNISC_BIT_UPDATE])
        begin
            succ_nxt = stage_r;
            if (!wrCtrl)
                ctrl1_nxt[TNISC_BIT_UPDATE] = 1'b0;
        end
        if (netEnter || scanFrameRx)
            succ_nxt = nextAddr(own_r);
        unique case (state_r)
            TNISC_IDLE:
            begin
                if (deadNetTimer && ctrl1_r[TNISC_BIT_INIT])
                begin
                    scanAddr_nxt = succ_r;
                    state_nxt = TNISC_PASS;
                end
            end
            TNISC_PASS:
            begin
                if (scanAddr_r == own_r)
                    state_nxt = TNISC_IDLE;
                else
                begin
                    tokenPass_nxt = 1'b1;
                    waitCnt_nxt = 16'(RESP_CYCLES);
                    state_nxt = TNISC_WAIT;
                end
            end
            TNISC_WAIT:
            begin
                if (netActivity)
                begin
                    succ_nxt = responder;
                    state_nxt = TNISC_IDLE;
                end
                else if (waitCnt_r == 16'h0001)
                begin
                    scanAddr_nxt = nextAddr(scanAddr_r);
                    state_nxt = TNISC_PASS;
                end
                else
                    waitCnt_nxt = waitCnt_r - 16'h0001;
            end
        endcase
        if (txEndValid && ctrl1_r[TNISC_BIT_PIGGY] && !txEnd.lastByChainEnd)
            piggy_nxt = txEnd.lastByLimit || txEnd.lastByStatus;
        if (bus.rd)
        begin
            unique case (bus.addr)
                TNISC_OFF_CTRL1: rdata_nxt = ctrl1_r;
                TNISC_OFF_STAGE: rdata_nxt = stage_r;
                TNISC_OFF_OWN: rdata_nxt = own_r;
                TNISC_OFF_SUCC: rdata_nxt = succ_r;
                TNISC_OFF_STAT: rdata_nxt = {7'h00, state_r != TNISC_IDLE};
                default: rdata_nxt = 8'h00;
            endcase
        end
        addrOut_nxt = dmaAddr;
        // with drive off the pins float except under acknowledge
        addrOe_nxt = ctrl1_r[TNISC_BIT_DRIVE] || ackLow_r;
        scanActive_nxt = state_nxt != TNISC_IDLE;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl1_r <= TNISC_CTRL1_RST;
            stage_r <= TNISC_ADDR_MIN;
            own_r <= TNISC_OWN_RST;
            succ_r <= TNISC_ADDR_MIN;
            scanAddr_r <= TNISC_ADDR_MIN;
            waitCnt_r <= 16'h0000;
            state_r <= TNISC_IDLE;
            tokenPass_r <= 1'b0;
            piggy_r <= 1'b0;
            rdata_r <= 8'h00;
            addrOut_r <= 16'h0000;
            addrOe_r <= 1'b0;
            scanActive_r <= 1'b0;
        end
        else
        begin
            ctrl1_r <= ctrl1_nxt;
            stage_r <= stage_nxt;
            own_r <= own_nxt;
            succ_r <= succ_nxt;
            scanAddr_r <= scanAddr_nxt;
            waitCnt_r <= waitCnt_nxt;
            state_r <= state_nxt;
            tokenPass_r <= tokenPass_nxt;
            piggy_r <= piggy_nxt;
            rdata_r <= rdata_nxt;
            addrOut_r <= addrOut_nxt;
            addrOe_r <= addrOe_nxt;
            scanActive_r <= scanActive_nxt;
        end
    end

    assign rdata = rdata_r;
    assign addrOut = addrOut_r;
    assign addrOe = addrOe_r;
    assign tokenPass = tokenPass_r;
    assign tokenDest = scanAddr_r;
    assign piggyback = piggy_r;
    assign scanActive = scanActive_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_drive_on;
        @(posedge clk) disable iff (!nrst) $past(ctrl1_r[TNISC_BIT_DRIVE]) |-> addrOe;
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("drive on but pins floating");

    property p_drive_off;
        @(posedge clk) disable iff (!nrst) !$past(ctrl1_r[TNISC_BIT_DRIVE]) && !$past(ackLow_r) |-> !addrOe;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("pins driven without ack");

    property p_no_init;
        @(posedge clk) disable iff (!nrst)
            state_r == TNISC_IDLE && deadNetTimer && !ctrl1_r[TNISC_BIT_INIT] |=> state_r == TNISC_IDLE;
    endproperty
    a_no_init: assert property (p_no_init) else $error("scan started with init clear");

    property p_scan_start;
        @(posedge clk) disable iff (!nrst)
            state_r == TNISC_IDLE && deadNetTimer && ctrl1_r[TNISC_BIT_INIT] |=> scanActive && scanAddr_r == $past(succ_r);
    endproperty
    a_scan_start: assert property (p_scan_start) else $error("scan not started at successor");

    property p_step;
        @(posedge clk) disable iff (!nrst)
            state_r == TNISC_WAIT && waitCnt_r == 16'h0001 && !netActivity |=> scanAddr_r == nextAddr($past(scanAddr_r));
    endproperty
    a_step: assert property (p_step) else $error("scan did not step upward");

    property p_range;
        @(posedge clk) disable iff (!nrst) tokenPass |-> tokenDest != 8'h00 && tokenDest != 8'hff;
    endproperty
    a_range: assert property (p_range) else $error("token pass to invalid address");

    property p_activity;
        @(posedge clk) disable iff (!nrst)
            state_r == TNISC_WAIT && netActivity |=> !scanActive && succ_r == $past(responder);
    endproperty
    a_activity: assert property (p_activity) else $error("scan did not end on response");

    property p_update;
        @(posedge clk) disable iff (!nrst)
            ctrl1_r[TNISC_BIT_UPDATE] && !wrCtrl && !netEnter && !scanFrameRx && state_r != TNISC_WAIT
            |=> succ_r == $past(stage_r) && !ctrl1_r[TNISC_BIT_UPDATE];
    endproperty
    a_update: assert property (p_update) else $error("successor update not applied");

    property p_chain_end;
        @(posedge clk) disable iff (!nrst) txEndValid && txEnd.lastByChainEnd |=> !piggyback;
    endproperty
    a_chain_end: assert property (p_chain_end) else $error("piggyback at chain end");

    property p_own_end;
        @(posedge clk) disable iff (!nrst) state_r == TNISC_PASS && scanAddr_r == own_r |=> !scanActive && !tokenPass;
    endproperty
    a_own_end: assert property (p_own_end) else $error("scan did not stop at own address");

    property p_net_enter;
        @(posedge clk) disable iff (!nrst)
            (netEnter || scanFrameRx) && !(state_r == TNISC_WAIT && netActivity) |=> succ_r == nextAddr($past(own_r));
    endproperty
    a_net_enter: assert property (p_net_enter) else $error("successor not reset to own plus one");

    property p_piggy;
        @(posedge clk) disable iff (!nrst)
            txEndValid && ctrl1_r[TNISC_BIT_PIGGY] && !txEnd.lastByChainEnd
            && (txEnd.lastByLimit || txEnd.lastByStatus) |=> piggyback;
    endproperty
    a_piggy: assert property (p_piggy) else $error("piggyback request not honoured");

    property p_window;
        @(posedge clk) disable iff (!nrst)
            state_r == TNISC_WAIT && !netActivity && waitCnt_r != 16'h0001
            |=> state_r == TNISC_WAIT && waitCnt_r == $past(waitCnt_r) - 16'h0001;
    endproperty
    a_window: assert property (p_window) else $error("response window cut short");

    property p_token_once;
        @(posedge clk) disable iff (!nrst) tokenPass |-> state_r == TNISC_WAIT && waitCnt_r == 16'(RESP_CYCLES);
    endproperty
    a_token_once: assert property (p_token_once) else $error("token pass without full window");
endmodule : tnisc_core

// [tnisc_peer.sv]
`timescale 1ns/1ns
// a peer node that answers a token pass to its own address
module tnisc_peer
    import tnisc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic tokenPass, // token pass from the block
    input wire logic [7:0] tokenDest, // destination of that pass
    input wire logic [7:0] peerAddr, // this peer's node address
    input wire logic [1:0] lag, // answer delay in cycles
    output logic netActivity, // pulse: this peer responds
    output logic [7:0] responder // responding address, valid with netActivity
);
    logic pend;
    logic [1:0] cnt;
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend <= 1'b0;
            cnt <= 2'h0;
            netActivity <= 1'b0;
            responder <= 8'h00;
        end
        else
        begin
            netActivity <= 1'b0;
            // released bus keeps toggling so a stale value never passes
            responder <= ~responder;
            if (tokenPass && tokenDest == peerAddr)
            begin
                pend <= 1'b1;
                cnt <= lag;
            end
            else if (pend && cnt != 2'h0)
                cnt <= cnt - 2'h1;
            else if (pend)
            begin
                pend <= 1'b0;
                netActivity <= 1'b1;
                responder <= peerAddr;
            end
        end
    end
endmodule : tnisc_peer

// [tnisc_tb_top.sv]
`timescale 1ns/1ns
module tnisc_tb_top
    import tnisc_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, dmaAckInN = 1'b1, deadNetTimer = 1'b0, netEnter = 1'b0;
    logic scanFrameRx = 1'b0, txEndValid = 1'b0, netActivity, tokenPass, piggyback, scanActive, addrOe;
    logic [7:0] rdata, responder, tokenDest, peerAddr = 8'h00, d, firstDest, lastDest;
    logic [15:0] dmaAddr = 16'ha5c3, addrOut;
    logic [1:0] lag = 2'h0;
    tnisc_bus_t bus = '0;
    tnisc_txend_t txEnd = '0;
    int n_fail = 0, comparisons = 0, nPass = 0, i;
    logic [27:0] regRow [6] = '{{4'h0, 8'hee, 8'h00, 8'he0}, {4'h1, 8'h10, 8'h01, 8'h10},
        {4'h2, 8'h05, 8'h01, 8'h05}, {4'h3, 8'h33, 8'h01, 8'h01}, {4'h4, 8'hff, 8'h00, 8'h00},
        {4'hf, 8'h5a, 8'h00, 8'h00}};
    // enable, limit, status, chain end, expected piggyback
    logic [4:0] pigRow [5] = '{5'b11001, 5'b10101, 5'b11010, 5'b10000, 5'b01000};
    always #5 clk = ~clk;
    // window of 4 lets a peer with one cycle of lag still be heard
    tnisc_core #(.RESP_CYCLES(4)) DUT (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .dmaAddr(dmaAddr),
        .dmaAckInN(dmaAckInN), .addrOut(addrOut), .addrOe(addrOe), .deadNetTimer(deadNetTimer),
        .netEnter(netEnter), .netActivity(netActivity), .responder(responder), .scanFrameRx(scanFrameRx),
        .txEnd(txEnd), .txEndValid(txEndValid), .tokenPass(tokenPass), .tokenDest(tokenDest),
        .piggyback(piggyback), .scanActive(scanActive));
    tnisc_peer peer (.clk(clk), .nrst(nrst), .tokenPass(tokenPass), .tokenDest(tokenDest),
        .peerAddr(peerAddr), .lag(lag), .netActivity(netActivity), .responder(responder));
    always @(posedge clk)
    begin
        if (tokenPass === 1'b1)
        begin
            if (nPass == 0)
                firstDest = tokenDest;
            lastDest = tokenDest;
            nPass++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask : rd
    task pulse(input int k);
        @(posedge clk);
        if (k == 0)
            deadNetTimer <= 1'b1;
        else if (k == 1)
            netEnter <= 1'b1;
        else
            scanFrameRx <= 1'b1;
        @(posedge clk);
        {deadNetTimer, netEnter, scanFrameRx} <= 3'b000;
    endtask : pulse
    task scan(input logic [7:0] succ, input int passes, input logic [7:0] first, input logic [7:0] last);
        wr(TNISC_OFF_STAGE, succ);
        wr(TNISC_OFF_CTRL1, 8'h21);
        nPass = 0;
        pulse(0);
        #1 chk(scanActive, 1'b1);
        i = 0;
        while (scanActive !== 1'b0 && i < 200)
        begin
            @(posedge clk);
            #1 i++;
        end
        chk(scanActive, 1'b0);
        chk(16'(nPass), 16'(passes));
        chk(firstDest, first);
        chk(lastDest, last);
    endtask : scan
    task tally_and_finish;
        if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300000 n_fail++;
        tally_and_finish;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (regRow[r])
        begin
            rd(regRow[r][27:24], regRow[r][15:8]);
            wr(regRow[r][27:24], regRow[r][23:16]);
            rd(regRow[r][27:24], regRow[r][7:0]);
        end
        wr(TNISC_OFF_CTRL1, 8'h21);
        rd(TNISC_OFF_SUCC, 8'h10);
        rd(TNISC_OFF_CTRL1, 8'h20);
        pulse(1);
        rd(TNISC_OFF_SUCC, 8'h06);
        wr(TNISC_OFF_STAGE, 8'h30);
        wr(TNISC_OFF_CTRL1, 8'h21);
        pulse(2);
        rd(TNISC_OFF_SUCC, 8'h06);
        peerAddr = 8'h08;
        lag = 2'h1;
        scan(8'h06, 3, 8'h06, 8'h08);
        rd(TNISC_OFF_SUCC, 8'h08);
        peerAddr = 8'h00;
        lag = 2'h0;
        scan(8'hfe, 5, 8'hfe, 8'h04);
        wr(TNISC_OFF_CTRL1, 8'h00);
        nPass = 0;
        pulse(0);
        repeat (8) @(posedge clk);
        #1 chk(scanActive, 1'b0);
        chk(16'(nPass), 16'h0000);
        wr(TNISC_OFF_OWN, 8'hfe);
        pulse(1);
        rd(TNISC_OFF_SUCC, 8'h01);
        repeat (6) @(posedge clk);
        #1 chk(addrOe, 1'b0);
        chk(addrOut, 16'ha5c3);
        @(posedge clk);
        dmaAckInN <= 1'b0;
        dmaAddr <= 16'h5a3c;
        repeat (6) @(posedge clk);
        #1 chk(addrOe, 1'b1);
        chk(addrOut, 16'h5a3c);
        @(posedge clk);
        dmaAckInN <= 1'b1;
        wr(TNISC_OFF_CTRL1, 8'h10);
        repeat (6) @(posedge clk);
        #1 chk(addrOe, 1'b1);
        foreach (pigRow[r])
        begin
            wr(TNISC_OFF_CTRL1, {1'b0, pigRow[r][4], 6'h00});
            @(posedge clk);
            txEnd <= pigRow[r][3:1];
            txEndValid <= 1'b1;
            @(posedge clk);
            txEndValid <= 1'b0;
            #1 chk(piggyback, pigRow[r][0]);
        end
        tally_and_finish;
    end
endmodule : tnisc_tb_top
